// ===== uefc_pkg.sv
// Function
// - scratch byte is plain read/write storage, kept in sleep, resets to FF.
// - feature bits 7:6 pick trigger table; tables A-C throttle at next levels.
// - feature bit 5 enables RS-485 direction control, overriding auto request throttling.
// - without direction control, transmit interrupt follows holding register empty.
// - direction output falls after last stop bit leaves the shift register.
// - direction output rises when a byte is written, before the start bit.
// - with direction control, transmit interrupt follows shift register empty.
// - direction output holds when only a flow-control character is sent.
// - feature bit 4 inverts the infrared receive input when set.
// - hysteresis field applies only with table D; zero means next trigger level.
// - codes 0-7 give 0,4,6,8,8,16,24,32; codes 12-15 give 12,20,28,36.
// - codes 8-11 give 40,44,48,52 characters around the trigger.
// - enhanced bits 3:0 select single or dual flow-control characters.
// - enhanced bit 7 halts transmit while the selected clear input is high.
// - enhanced bit 6 interrupts at trigger and raises request at upper level.
// - request output returns low when level falls below the lower level.
// - request output must be driven low first before throttling takes effect.
// - without hardware flow control, request pin is a software output.
// - enhanced bit 5 compares received chars with second pause char, sets status bit 2.
// - with second pair compared, second pause char is not stored, raises both interrupts.
// - enhanced bit 4 gates writes to enhanced bits 7:5; clearing it locks them.
// - modem control bit 2 picks CTS/RTS at 0, DSR/DTR at 1.
// Purpose: constants of the enhanced feature and flow-control block
// Assumes: classic wishbone, 32-bit data, byte-wide registers in low lanes
// Notes: none
package uefc_pkg;
	localparam logic [3:0] UEFC_ADDR_SCRATCH = 4'h0;
	localparam logic [3:0] UEFC_ADDR_FEATURE = 4'h4;
	localparam logic [3:0] UEFC_ADDR_ENHANCED = 4'h8;
	localparam logic [3:0] UEFC_ADDR_STATUS = 4'hC;
	localparam logic [7:0] UEFC_SCRATCH_RST = 8'hFF;
	localparam logic [7:0] UEFC_FEATURE_RST = 8'h00;
	localparam logic [7:0] UEFC_ENHANCED_RST = 8'h00;
	localparam int UEFC_FC_TABLE_HI = 7;
	localparam int UEFC_FC_TABLE_LO = 6;
	localparam int UEFC_FC_DIR_EN = 5;
	localparam int UEFC_FC_IR_INV = 4;
	localparam int UEFC_EF_AUTO_CLR = 7;
	localparam int UEFC_EF_AUTO_REQ = 6;
	localparam int UEFC_EF_SPECIAL = 5;
	localparam int UEFC_EF_WR_EN = 4;
	localparam logic [1:0] UEFC_TABLE_D = 2'h3;
	localparam logic [1:0] UEFC_RX_PAIR1 = 2'h2;
	localparam logic [1:0] UEFC_RX_PAIR2 = 2'h1;
	localparam logic [7:0] UEFC_LEVEL_MAX = 8'hFF;
	typedef enum logic [1:0] {UEFC_DIR_IDLE, UEFC_DIR_SEND, UEFC_DIR_DRAIN} uefc_dir_t;
endpackage

// ===== uefc_core.sv
// Purpose: enhanced feature, flow-control and direction logic of one UART channel
// Assumes: fifo levels, triggers and shifter status come from the channel core
// Notes: request/clear pins are active low as levels on RTS_N, DTR_N, CTS_N, DSR_N
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module uefc_core (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [3:2] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	input wire logic [7:0] RX_LEVEL,
	input wire logic [7:0] RX_TRIGGER,
	input wire logic [7:0] RX_NEXT_UPPER,
	input wire logic [7:0] RX_NEXT_LOWER,
	input wire logic THR_WRITE,
	input wire logic THR_EMPTY,
	input wire logic TSR_EMPTY,
	input wire logic FLOW_CHAR_ONLY,
	input wire logic RX_CHAR_VALID,
	input wire logic [7:0] RX_CHAR,
	input wire logic [7:0] SECOND_PAUSE_CHAR,
	input wire logic MCR_SELECT_DTR,
	input wire logic MCR_REQ_SW,
	input wire logic MCR_TERM_SW,
	input wire logic CTS_N,
	input wire logic DSR_N,
	input wire logic IR_RX,
	output logic IR_RX_DECODED,
	output logic TX_HALT,
	output logic TX_INT,
	output logic RX_TRIG_INT,
	output logic SPECIAL_INT,
	output logic PAUSE_INT,
	output logic RX_STORE,
	output logic RTS_N,
	output logic DTR_N
);
	logic [7:0] scratch_reg;
	logic [7:0] feature_reg;
	logic [7:0] enhanced_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic throttle_reg;
	logic special_reg;
	logic pause_reg;
	logic store_reg;
	logic dir_out_reg;
	uefc_pkg::uefc_dir_t dir_reg;
	uefc_pkg::uefc_dir_t dir_next;
	logic txint_reg;
	logic halt_reg;

	function automatic logic [5:0] hyst_of(input logic [3:0] code);
		case (code)
			4'h0: hyst_of = 6'h00;
			4'h1: hyst_of = 6'h04;
			4'h2: hyst_of = 6'h06;
			4'h3: hyst_of = 6'h08;
			4'h4: hyst_of = 6'h08;
			4'h5: hyst_of = 6'h10;
			4'h6: hyst_of = 6'h18;
			4'h7: hyst_of = 6'h20;
			4'h8: hyst_of = 6'h28;
			4'h9: hyst_of = 6'h2C;
			4'hA: hyst_of = 6'h30;
			4'hB: hyst_of = 6'h34;
			4'hC: hyst_of = 6'h0C;
			4'hD: hyst_of = 6'h14;
			4'hE: hyst_of = 6'h1C;
			default: hyst_of = 6'h24;
		endcase
	endfunction

	// bus decode
	wire bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
	// write commits on the edge at which the master sees ack, not on the taking edge
	wire wr_lane0 = WB_CYC_I && WB_STB_I && ack_reg && WB_WE_I && WB_SEL_I[0];
	wire [3:0] byte_addr = {WB_ADR_I, 2'b00};
	wire hit_scratch = byte_addr == uefc_pkg::UEFC_ADDR_SCRATCH;
	wire hit_feature = byte_addr == uefc_pkg::UEFC_ADDR_FEATURE;
	wire hit_enhanced = byte_addr == uefc_pkg::UEFC_ADDR_ENHANCED;
	wire hit_status = byte_addr == uefc_pkg::UEFC_ADDR_STATUS;
	wire wr_en_bits = enhanced_reg[uefc_pkg::UEFC_EF_WR_EN];
	wire [7:0] wdat = WB_DAT_I[7:0];

	// mode decode
	wire dir_en = feature_reg[uefc_pkg::UEFC_FC_DIR_EN];
	wire [1:0] table_sel = feature_reg[uefc_pkg::UEFC_FC_TABLE_HI:uefc_pkg::UEFC_FC_TABLE_LO];
	wire [3:0] hyst_code = feature_reg[3:0];
	wire use_hyst = (table_sel == uefc_pkg::UEFC_TABLE_D) && (hyst_code != 4'h0);
	wire [5:0] hyst = hyst_of(hyst_code);
	wire [8:0] up_sum = {1'b0, RX_TRIGGER} + {3'b000, hyst};
	wire [7:0] up_hyst = up_sum[8] ? uefc_pkg::UEFC_LEVEL_MAX : up_sum[7:0];
	wire [8:0] lo_dif = {1'b0, RX_TRIGGER} - {3'b000, hyst};
	wire [7:0] lo_hyst = lo_dif[8] ? 8'h00 : lo_dif[7:0];
	wire [7:0] up_level = use_hyst ? up_hyst : RX_NEXT_UPPER;
	wire [7:0] lo_level = use_hyst ? lo_hyst : RX_NEXT_LOWER;
	wire auto_req = enhanced_reg[uefc_pkg::UEFC_EF_AUTO_REQ] && !dir_en;
	wire req_sw_low = MCR_SELECT_DTR ? MCR_TERM_SW : MCR_REQ_SW;
	wire throttle_set = RX_LEVEL >= up_level;
	wire throttle_clr = RX_LEVEL < lo_level;
	wire clear_in_n = MCR_SELECT_DTR ? DSR_N : CTS_N;
	wire special_en = enhanced_reg[uefc_pkg::UEFC_EF_SPECIAL];
	wire char_match = RX_CHAR_VALID && (RX_CHAR == SECOND_PAUSE_CHAR);
	wire rx_pair2 = enhanced_reg[1:0] == uefc_pkg::UEFC_RX_PAIR2;
	wire hit_special = special_en && char_match;
	wire swallow = hit_special && rx_pair2;
	wire flow_on = enhanced_reg[3:0] != 4'h0;
	wire dir_hold = flow_on && FLOW_CHAR_ONLY && THR_EMPTY;
	wire req_out_high = dir_en ? dir_out_reg : (auto_req ? throttle_reg : 1'b0);
	// request pin high until software drives it low; throttle or direction output lifts it
	wire req_pin_n = !req_sw_low || req_out_high;
	wire [31:0] rd_mux = hit_scratch ? {24'h000000, scratch_reg} :
		hit_feature ? {24'h000000, feature_reg} :
		hit_enhanced ? {24'h000000, enhanced_reg} :
		hit_status ? {24'h000000, 2'b00, dir_reg == uefc_pkg::UEFC_DIR_IDLE, halt_reg,
			throttle_reg, special_reg, pause_reg, dir_out_reg} : 32'h00000000;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg <= bus_req;
			rdata_reg <= bus_req ? rd_mux : rdata_reg;
		end
	end

	// sleep does not touch this register, only reset
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			scratch_reg <= uefc_pkg::UEFC_SCRATCH_RST;
		else if (wr_lane0 && hit_scratch)
			scratch_reg <= wdat;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			feature_reg <= uefc_pkg::UEFC_FEATURE_RST;
		else if (wr_lane0 && hit_feature)
			feature_reg <= wdat;
	end

	// bits 7:5 locked while the write enable is clear; flow select always writable
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			enhanced_reg <= uefc_pkg::UEFC_ENHANCED_RST;
		else if (wr_lane0 && hit_enhanced && wr_en_bits)
			enhanced_reg <= wdat;
		else if (wr_lane0 && hit_enhanced)
			enhanced_reg <= {enhanced_reg[7:5], wdat[uefc_pkg::UEFC_EF_WR_EN], wdat[3:0]};
	end

	// throttle with hysteresis; hold between levels
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			throttle_reg <= 1'b0;
		else if (!auto_req || !req_sw_low)
			throttle_reg <= 1'b0;
		else if (throttle_set)
			throttle_reg <= 1'b1;
		else if (throttle_clr)
			throttle_reg <= 1'b0;
	end

	always_comb begin
		dir_next = dir_reg;
		case (dir_reg)
			uefc_pkg::UEFC_DIR_IDLE: if (THR_WRITE) dir_next = uefc_pkg::UEFC_DIR_SEND;
			uefc_pkg::UEFC_DIR_SEND: if (THR_EMPTY) dir_next = uefc_pkg::UEFC_DIR_DRAIN;
			uefc_pkg::UEFC_DIR_DRAIN: begin
				if (THR_WRITE)
					dir_next = uefc_pkg::UEFC_DIR_SEND;
				else if (TSR_EMPTY)
					dir_next = uefc_pkg::UEFC_DIR_IDLE;
			end
			default: dir_next = uefc_pkg::UEFC_DIR_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			dir_reg <= uefc_pkg::UEFC_DIR_IDLE;
			dir_out_reg <= 1'b0;
		end else begin
			dir_reg <= dir_next;
			if (!dir_en || dir_hold)
				dir_out_reg <= dir_out_reg && dir_en;
			else if (THR_WRITE)
				dir_out_reg <= 1'b1;
			else if (dir_next == uefc_pkg::UEFC_DIR_IDLE)
				dir_out_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			txint_reg <= 1'b0;
			halt_reg <= 1'b0;
			special_reg <= 1'b0;
			pause_reg <= 1'b0;
			store_reg <= 1'b0;
		end else begin
			txint_reg <= dir_en ? TSR_EMPTY : THR_EMPTY;
			halt_reg <= enhanced_reg[uefc_pkg::UEFC_EF_AUTO_CLR] && clear_in_n;
			special_reg <= hit_special;
			pause_reg <= swallow;
			store_reg <= RX_CHAR_VALID && !swallow;
		end
	end

	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = rdata_reg;
	assign IR_RX_DECODED = feature_reg[uefc_pkg::UEFC_FC_IR_INV] ? !IR_RX : IR_RX;
	assign TX_HALT = halt_reg;
	assign TX_INT = txint_reg;
	assign RX_TRIG_INT = enhanced_reg[uefc_pkg::UEFC_EF_AUTO_REQ] && (RX_LEVEL >= RX_TRIGGER);
	assign SPECIAL_INT = special_reg;
	assign PAUSE_INT = pause_reg;
	assign RX_STORE = store_reg;
	// unselected pin stays a plain software output
	assign RTS_N = MCR_SELECT_DTR ? !MCR_REQ_SW : req_pin_n;
	assign DTR_N = MCR_SELECT_DTR ? req_pin_n : !MCR_TERM_SW;

	ack_one_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
	scratch_wr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		wr_lane0 && hit_scratch |=> scratch_reg == $past(wdat)) else $error("scratch lost");
	dir_rise_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en && THR_WRITE && !dir_hold |=> dir_out_reg) else $error("dir not raised");
	dir_off_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!dir_en |=> !dir_out_reg) else $error("dir active while disabled");
	halt_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		enhanced_reg[uefc_pkg::UEFC_EF_AUTO_CLR] && clear_in_n |=> TX_HALT) else $error("no halt");
	throttle_up_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		auto_req && req_sw_low && throttle_set |=> throttle_reg) else $error("no throttle");
	throttle_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!req_sw_low |=> !throttle_reg) else $error("throttle before assert");
	swallow_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		swallow |=> !RX_STORE && PAUSE_INT && SPECIAL_INT) else $error("second_pause_char stored");
	txint_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en && !TSR_EMPTY |=> !TX_INT) else $error("tx int early");

	// bus answer and read data
	ack_after_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		bus_req
		|=> WB_ACK_O) else $error("request not acked");

	ack_only_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!bus_req
		|=> !WB_ACK_O) else $error("ack without request");

	rdata_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!bus_req
		|=> $stable(WB_DAT_O)) else $error("read data moved");

	// register reset values, checked while reset is held; register writes, lock and hold
	scratch_rst_a: assert property (@(posedge CLOCK)
		!RST_N
		|=> scratch_reg == uefc_pkg::UEFC_SCRATCH_RST) else $error("scratch reset");

	feature_rst_a: assert property (@(posedge CLOCK)
		!RST_N
		|=> feature_reg == uefc_pkg::UEFC_FEATURE_RST) else $error("feature reset");

	enh_rst_a: assert property (@(posedge CLOCK)
		!RST_N
		|=> enhanced_reg == uefc_pkg::UEFC_ENHANCED_RST) else $error("enhanced reset");

	scratch_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!(wr_lane0 && hit_scratch)
		|=> $stable(scratch_reg)) else $error("scratch changed");

	feature_wr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		wr_lane0 && hit_feature
		|=> feature_reg == $past(wdat)) else $error("feature not written");

	feature_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!(wr_lane0 && hit_feature)
		|=> $stable(feature_reg)) else $error("feature changed");

	enh_open_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		wr_lane0 && hit_enhanced && wr_en_bits
		|=> enhanced_reg == $past(wdat)) else $error("enhanced not written");

	enh_lock_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		wr_lane0 && hit_enhanced && !wr_en_bits
		|=> enhanced_reg[7:5] == $past(enhanced_reg[7:5])) else $error("locked bits moved");

	flow_sel_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		wr_lane0 && hit_enhanced
		|=> enhanced_reg[3:0] == $past(wdat[3:0])) else $error("flow select lost");

	enh_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!(wr_lane0 && hit_enhanced)
		|=> $stable(enhanced_reg)) else $error("enhanced changed");

	// direction output
	dir_fall_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en && !dir_hold && !THR_WRITE && dir_next == uefc_pkg::UEFC_DIR_IDLE
		|=> !dir_out_reg) else $error("dir not released");

	dir_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en && dir_hold
		|=> dir_out_reg == $past(dir_out_reg)) else $error("dir moved on flow char");

	req_pin_dir_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en && req_sw_low
		|-> req_pin_n == dir_out_reg) else $error("dir pin wrong");

	dir_over_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en
		|=> !throttle_reg) else $error("throttle under dir control");

	// transmit interrupt source and halt
	txint_thr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!dir_en
		|=> TX_INT == $past(THR_EMPTY)) else $error("tx int not holding empty");

	txint_tsr_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		dir_en
		|=> TX_INT == $past(TSR_EMPTY)) else $error("tx int not shift empty");

	halt_release_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!clear_in_n
		|=> !TX_HALT) else $error("halt while clear low");

	halt_off_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!enhanced_reg[uefc_pkg::UEFC_EF_AUTO_CLR]
		|=> !TX_HALT) else $error("halt while disabled");

	// receive throttling
	throttle_down_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		auto_req && req_sw_low && !throttle_set && throttle_clr
		|=> !throttle_reg) else $error("throttle not released");

	throttle_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		auto_req && req_sw_low && !throttle_set && !throttle_clr
		|=> throttle_reg == $past(throttle_reg)) else $error("throttle moved in band");

	hyst_next_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!use_hyst
		|-> up_level == RX_NEXT_UPPER && lo_level == RX_NEXT_LOWER) else $error("hyst misuse");

	trig_int_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		enhanced_reg[uefc_pkg::UEFC_EF_AUTO_REQ] && RX_LEVEL >= RX_TRIGGER
		|-> RX_TRIG_INT) else $error("no trigger interrupt");

	// pins
	req_pin_sw_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!auto_req && !dir_en
		|-> req_pin_n == !req_sw_low) else $error("pin not software");

	rts_sel_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!MCR_SELECT_DTR
		|-> RTS_N == req_pin_n && DTR_N == !MCR_TERM_SW) else $error("rts pair wrong");

	dtr_sel_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		MCR_SELECT_DTR
		|-> DTR_N == req_pin_n && RTS_N == !MCR_REQ_SW) else $error("dtr pair wrong");

	ir_pol_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		IR_RX_DECODED == (IR_RX ^ feature_reg[uefc_pkg::UEFC_FC_IR_INV]))
		else $error("ir polarity");

	// special character path
	special_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		hit_special
		|=> SPECIAL_INT) else $error("special missed");

	special_none_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!hit_special
		|=> !SPECIAL_INT) else $error("false special");

	store_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		RX_CHAR_VALID && !swallow
		|=> RX_STORE) else $error("char not stored");

	store_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!RX_CHAR_VALID
		|=> !RX_STORE) else $error("store without char");

	cov_dir_c: cover property (@(posedge CLOCK) dir_out_reg ##[1:50] !dir_out_reg);
	cov_thr_c: cover property (@(posedge CLOCK) throttle_reg ##[1:50] !throttle_reg);
	cov_spec_c: cover property (@(posedge CLOCK) SPECIAL_INT);
	cov_swal_c: cover property (@(posedge CLOCK) swallow);
	cov_halt_c: cover property (@(posedge CLOCK) TX_HALT ##[1:20] !TX_HALT);
endmodule

// ===== uefc_far_end.sv
// Purpose: far-end serial device driving clear inputs and infrared line
// Assumes: pause requests come from the bench
// Notes: infrared line toggles every cycle so it never rests on a stale value
`timescale 1ns/1ps
module uefc_far_end (
	input wire logic CLOCK,
	input wire logic pause_cts,
	input wire logic pause_dsr,
	output logic CTS_N,
	output logic DSR_N,
	output logic IR_RX
);
	initial IR_RX = 1'b0;
	always @(posedge CLOCK) begin
		CTS_N <= pause_cts;
		DSR_N <= pause_dsr;
		IR_RX <= ~IR_RX;
	end
endmodule

// ===== test_uart_enhanced_flow_control.sv
// Purpose: register and flow-control checks of the enhanced feature block
// Assumes: one wishbone master, far-end model on the clear inputs
// Notes: outputs are read right after an edge, before that edge's updates land
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module test_uart_enhanced_flow_control;
	logic CLOCK = 0, RST_N = 0, we = 0, cyc = 0, stb = 0, ack;
	logic [1:0] adr = 0;
	logic [31:0] wdat = 0, rdat;
	logic [7:0] lvl = 0, trig = 0, up = 0, lo = 0, ch = 0, q;
	logic thw = 0, the = 1, tse = 1, fco = 0, chv = 0, dsel = 0, req = 0, term = 0;
	logic p_cts = 0, p_dsr = 0;
	logic cts_n, dsr_n, ir, ird, halt, txi, trgi, spi, pai, sto, rts_n, dtr_n;
	int num_errors = 0, samples_checked = 0;
	int hy[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
	int lv[6] = '{55, 56, 60, 20, 16, 15};
	logic ex[6] = '{0, 0, 1, 1, 1, 0};
	uefc_far_end i_uefc_far_end (.CLOCK(CLOCK), .pause_cts(p_cts), .pause_dsr(p_dsr),
		.CTS_N(cts_n), .DSR_N(dsr_n), .IR_RX(ir));
	uefc_core i_uefc_core (.CLOCK(CLOCK), .RST_N(RST_N), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_ACK_O(ack), .RX_LEVEL(lvl), .RX_TRIGGER(trig), .RX_NEXT_UPPER(up),
		.RX_NEXT_LOWER(lo), .THR_WRITE(thw), .THR_EMPTY(the), .TSR_EMPTY(tse),
		.FLOW_CHAR_ONLY(fco), .RX_CHAR_VALID(chv), .RX_CHAR(ch), .SECOND_PAUSE_CHAR(8'h5A),
		.MCR_SELECT_DTR(dsel), .MCR_REQ_SW(req), .MCR_TERM_SW(term), .CTS_N(cts_n),
		.DSR_N(dsr_n), .IR_RX(ir), .IR_RX_DECODED(ird), .TX_HALT(halt), .TX_INT(txi),
		.RX_TRIG_INT(trgi), .SPECIAL_INT(spi), .PAUSE_INT(pai), .RX_STORE(sto),
		.RTS_N(rts_n), .DTR_N(dtr_n));
	task close_out();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task go(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	// request held until ack is seen at an edge; no fixed latency assumed
	task wb(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		adr <= a[3:2];
		wdat <= {24'h000000, d};
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
		end while (ack !== 1'b1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			close_out();
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge CLOCK);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		wb(a, 1'b1, d);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		wb(a, 1'b0, 8'h00);
		`CHK(q, e)
	endtask
	task rx(input logic [7:0] c);
		ch <= c;
		chv <= 1'b1;
		@(posedge CLOCK);
		chv <= 1'b0;
		@(posedge CLOCK);
	endtask
	initial begin
		forever #2 CLOCK = ~CLOCK;
	end
	initial begin
		repeat (20000) @(posedge CLOCK);
		num_errors++;
		close_out();
	end
	initial begin
		go(20);
		RST_N <= 1'b1;
		go(1);
		rd(4'h0, 8'hFF);
		rd(4'h4, 8'h00);
		rd(4'h8, 8'h00);
		wr(4'h0, 8'h3C);
		rd(4'h0, 8'h3C);
		req <= 1'b1;
		term <= 1'b1;
		go(2);
		`CHK(rts_n, 1'b0)
		`CHK(dtr_n, 1'b0)
		`CHK(ird, ir)
		wr(4'h4, 8'h10);
		`CHK(ird, ~ir)
		tse <= 1'b0;
		go(2);
		`CHK(txi, 1'b1)
		wr(4'h4, 8'h20);
		go(1);
		`CHK(txi, 1'b0)
		wr(4'h8, 8'h10);
		wr(4'h8, 8'h58);
		lvl <= 8'd200;
		trig <= 8'd100;
		up <= 8'd110;
		lo <= 8'd90;
		fco <= 1'b1;
		go(2);
		`CHK(rts_n, 1'b0)
		fco <= 1'b0;
		thw <= 1'b1;
		the <= 1'b0;
		go(1);
		thw <= 1'b0;
		go(1);
		`CHK(rts_n, 1'b1)
		the <= 1'b1;
		go(2);
		`CHK(rts_n, 1'b1)
		tse <= 1'b1;
		go(2);
		`CHK(rts_n, 1'b0)
		`CHK(txi, 1'b1)
		wr(4'h8, 8'h90);
		p_cts <= 1'b1;
		go(3);
		`CHK(halt, 1'b1)
		dsel <= 1'b1;
		go(3);
		`CHK(halt, 1'b0)
		p_dsr <= 1'b1;
		go(3);
		`CHK(halt, 1'b1)
		dsel <= 1'b0;
		wr(4'h4, 8'h00);
		wr(4'h8, 8'h50);
		req <= 1'b0;
		lvl <= 8'd0;
		trig <= 8'd56;
		up <= 8'd60;
		lo <= 8'd16;
		go(2);
		`CHK(rts_n, 1'b1)
		req <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			lvl <= 8'(lv[i]);
			go(2);
			`CHK(rts_n, ex[i])
			`CHK(trgi, logic'(lv[i] >= 56))
		end
		trig <= 8'd100;
		for (int c = 1; c < 16; c++) begin
			wr(4'h4, 8'hC0 | 8'(c));
			for (int j = 0; j < 4; j++) begin
				lvl <= 8'((j < 2 ? 100 + hy[c] : 100 - hy[c]) - (j == 0 || j == 3));
				go(2);
				`CHK(rts_n, logic'(j == 1 || j == 2))
			end
		end
		dsel <= 1'b1;
		lvl <= 8'd200;
		go(2);
		`CHK(dtr_n, 1'b1)
		wr(4'h8, 8'h10);
		wr(4'h8, 8'h32);
		rx(8'h5A);
		`CHK({spi, sto}, 2'b11)
		rx(8'h5B);
		`CHK(spi, 1'b0)
		wr(4'h8, 8'h30);
		wr(4'h8, 8'h31);
		rx(8'h5A);
		`CHK({spi, pai, sto}, 3'b110)
		wr(4'h8, 8'h00);
		wr(4'h8, 8'hE0);
		rd(4'h8, 8'h00);
		rd(4'hC, 8'h20);
		close_out();
	end
endmodule
